// File: link_ctrl_pkg.sv
// Package for the target-information clear and link-instruction gating block.
// Assumes a single clock domain and a plain register port on the host side.
`default_nettype none
package link_ctrl_pkg;
  localparam logic [11:0] CLEAR_REQ_ADDR = 12'h080;
  localparam logic [11:0] CH1_SEQ_ADDR = 12'h255;
  localparam logic [11:0] CH2_SEQ_ADDR = 12'h265;
  localparam logic [11:0] LINK_CFG_ADDR = 12'h300;
  localparam logic [11:0] LINK_CMD_ADDR = 12'h302;
  localparam logic [11:0] LINK_STAT_ADDR = 12'h304;
  localparam logic [15:0] CLEAR_KEY = 16'h4C43;
  localparam logic [15:0] CLEAR_DONE = 16'h0000;
  localparam logic [15:0] SEQ_RESET_VALUE = 16'h0000;
  localparam logic [15:0] CLEAR_REQ_RESET = 16'h0000;
  localparam logic [7:0] HEAD_IO_MAX = 8'hFE;
  localparam logic [2:0] FORMAT_MIN = 3'h1;
  localparam logic [2:0] FORMAT_MAX = 3'h5;
  localparam int CLEAR_TIME_NS = 400;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLEAR_CYCLES = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Per channel: protocol format, link-operation enable, multidrop wiring
  typedef struct packed {
    logic [2:0] format;
    logic link_enable;
    logic multidrop;
  } chan_cfg_t;

  // Link command word: bit0 channel, bit1 receive, bit2 broadcast, [15:8] head io
  typedef struct packed {
    logic [7:0] head_io;
    logic [4:0] spare;
    logic broadcast;
    logic receive;
    logic channel;
  } link_cmd_t;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'b00,
    CLR_BUSY = 2'b01,
    CLR_DONE = 2'b10
  } clear_state_t;
endpackage : link_ctrl_pkg
`default_nettype wire

// File: link_ctrl.sv
// Target-information clear handshake and link-instruction gating for two channels.
// Assumes the host, the serial engines and the internal memory sit on ref_clk.
`default_nettype none
// How it works
// - Module writes zero there when clear completes
// - Clear reinitialises both sequence status words
// - Serial data during clear is discarded
// - Clear drops the modem line
// - Links only on dedicated formats, link disabled
// - Second link on busy channel ends abnormally
// - Send writes remote memory, receive reads local
// - Point-to-point one-to-one only; multidrop any
module link_ctrl
  import link_ctrl_pkg::*;
#(
  parameter int CLEAR_LEN = CLEAR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,

  input wire logic [15:0] ch1_seq_in,
  input wire logic [15:0] ch2_seq_in,

  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,

  output logic modem_hangup,
  output logic clear_busy,

  output logic link_start,
  output logic link_to_remote_mem,
  output logic link_from_local_mem,
  output logic link_channel,
  input wire logic [1:0] link_finished,
  input wire logic link_failed,
  output logic link_done,
  output logic link_abnormal
);
  initial begin
    if (CLEAR_LEN < 1) $error("CLEAR_LEN must be at least 1");
    // The port checker bounds a whole clear at 200 cycles
    if (CLEAR_LEN > 198) $error("CLEAR_LEN must be at most 198");
  end

  localparam int CW = $clog2(CLEAR_LEN + 1);

  reg_req_t req;
  clear_state_t state, next_state;
  logic [15:0] clear_req;
  logic [15:0] ch1_seq, ch2_seq;
  logic ch1_seq_hold, ch2_seq_hold;

  logic [CW-1:0] clear_cnt;

  chan_cfg_t cfg [2];
  logic [1:0] chan_busy;
  logic chan_err;
  logic [7:0] last_err;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Relay only on dedicated-protocol formats with link operation off
  function automatic logic link_allowed(input chan_cfg_t c);
    link_allowed = (c.format >= FORMAT_MIN) && (c.format <= FORMAT_MAX) && !c.link_enable;
  endfunction : link_allowed

  logic wr_clear;
  logic key_written;
  logic wr_cfg;
  logic wr_cmd;
  logic rd_status;
  link_cmd_t cmd;
  logic cmd_ok_cfg;
  logic cmd_ok_io;
  logic cmd_ok_topo;
  logic cmd_busy;
  logic cmd_accept;
  logic cmd_reject;
  logic clear_end;

  assign wr_clear = req.wr && (req.addr == CLEAR_REQ_ADDR);
  // A key that lands while a clear is still running or finishing starts nothing
  assign key_written = wr_clear && (req.wdata == CLEAR_KEY) && (state == CLR_IDLE);
  assign wr_cfg = req.wr && (req.addr == LINK_CFG_ADDR);
  assign wr_cmd = req.wr && (req.addr == LINK_CMD_ADDR);
  assign rd_status = req.rd && (req.addr == LINK_STAT_ADDR);
  assign cmd = link_cmd_t'(req.wdata);

  // Refusal reasons stay apart so the status word can report busy, head io and topology, but not format
  assign cmd_ok_cfg = link_allowed(cfg[cmd.channel]);
  assign cmd_ok_io = cmd.head_io <= HEAD_IO_MAX;
  // Broadcast only makes sense on a multidrop line
  assign cmd_ok_topo = !cmd.broadcast || cfg[cmd.channel].multidrop;
  assign cmd_busy = chan_busy[cmd.channel] || (state != CLR_IDLE);
  assign cmd_accept = wr_cmd && cmd_ok_cfg && cmd_ok_io && cmd_ok_topo && !cmd_busy;
  assign cmd_reject = wr_cmd && !cmd_accept;

  assign clear_end = (state == CLR_BUSY) && (clear_cnt == CW'(CLEAR_LEN - 1));

  // DONE lasts one cycle: the word is zeroed there and the host sees it next
  always_comb begin
    next_state = state;
    unique case (state)
      CLR_IDLE: if (key_written) next_state = CLR_BUSY;
      CLR_BUSY: if (clear_end) next_state = CLR_DONE;
      CLR_DONE: next_state = CLR_IDLE;
      default: next_state = CLR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= CLR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counts only while busy, so every clear stays in CLR_BUSY for exactly CLEAR_LEN cycles, with one DONE cycle after
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clear_cnt <= '0;
    end else begin
      clear_cnt <= (state == CLR_BUSY) ? clear_cnt + CW'(1) : '0;
    end
  end

  // Clear request word: host value is held; completion overwrites with zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clear_req <= CLEAR_REQ_RESET;
    end else if (state == CLR_DONE) begin
      clear_req <= CLEAR_DONE;
    end else if (wr_clear && state == CLR_IDLE) begin
      clear_req <= req.wdata;
    end
  end

  // Sequence status mirrors engine state, forced to initial value by a clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ch1_seq <= SEQ_RESET_VALUE;
      ch1_seq_hold <= 1'b0;
    end else if (state != CLR_IDLE) begin
      ch1_seq <= SEQ_RESET_VALUE;
      ch1_seq_hold <= 1'b1;
    end else begin
      ch1_seq <= ch1_seq_hold ? SEQ_RESET_VALUE : ch1_seq_in;
      // Hold the initial value until the engine itself reports the initial value
      ch1_seq_hold <= ch1_seq_hold && (ch1_seq_in != SEQ_RESET_VALUE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ch2_seq <= SEQ_RESET_VALUE;
      ch2_seq_hold <= 1'b0;
    end else if (state != CLR_IDLE) begin
      ch2_seq <= SEQ_RESET_VALUE;
      ch2_seq_hold <= 1'b1;
    end else begin
      ch2_seq <= ch2_seq_hold ? SEQ_RESET_VALUE : ch2_seq_in;
      ch2_seq_hold <= ch2_seq_hold && (ch2_seq_in != SEQ_RESET_VALUE);
    end
  end

  assign clear_busy = (state != CLR_IDLE);

  // Received bytes are registered through; dropped while a clear runs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_out_valid <= 1'b0;
      rx_out_data <= 8'h00;
    end else begin
      rx_out_valid <= rx_valid && (state == CLR_IDLE) && !key_written;
      rx_out_data <= rx_data;
    end
  end

  // The modem line drops on the key edge itself, together with busy
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      modem_hangup <= 1'b0;
    end else begin
      modem_hangup <= key_written || (state == CLR_BUSY);
    end
  end

  // Both channel settings share one word and change together
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg[0] <= '0;
    end else if (wr_cfg) begin
      cfg[0] <= chan_cfg_t'(req.wdata[4:0]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg[1] <= '0;
    end else if (wr_cfg) begin
      cfg[1] <= chan_cfg_t'(req.wdata[12:8]);
    end
  end

  // Channel busy: a new start sets it and wins over a finish; a finish clears only the channel it names
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chan_busy <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cmd_accept && cmd.channel == 1'(i)) begin
          chan_busy[i] <= 1'b1;
        end else if (link_finished[i]) begin
          chan_busy[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_start <= 1'b0;
      link_channel <= 1'b0;
      link_to_remote_mem <= 1'b0;
      link_from_local_mem <= 1'b0;
    end else begin
      link_start <= cmd_accept;
      if (cmd_accept) begin
        link_channel <= cmd.channel;
        link_to_remote_mem <= !cmd.receive;
        link_from_local_mem <= cmd.receive;
      end
    end
  end

  // One-cycle completion with its abnormal flag alongside; a refusal looks the same
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_done <= 1'b0;
      link_abnormal <= 1'b0;
    end else begin
      link_done <= cmd_reject || (|link_finished);
      link_abnormal <= cmd_reject || ((|link_finished) && link_failed);
    end
  end

  // Sticky error: a refusal in the same cycle as the status read wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      chan_err <= 1'b0;
      last_err <= 8'h00;
    end else if (cmd_reject) begin
      chan_err <= 1'b1;
      last_err <= {4'h0, 1'b0, !cmd_ok_topo, !cmd_ok_io, cmd_busy};
    end else if (rd_status) begin
      chan_err <= 1'b0;
    end
  end

  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    if (req.rd) begin
      unique case (req.addr)
        CLEAR_REQ_ADDR: next_rdata = clear_req;
        CH1_SEQ_ADDR: next_rdata = ch1_seq;
        CH2_SEQ_ADDR: next_rdata = ch2_seq;
        LINK_CFG_ADDR: next_rdata = {3'h0, cfg[1], 3'h0, cfg[0]};
        LINK_STAT_ADDR: next_rdata = {last_err, 3'h0, chan_err, clear_busy, 1'b0, chan_busy};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe; zero otherwise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : link_ctrl
`default_nettype wire

// File: link_ctrl_asserts.sv
// Port assertions for the clear handshake and link gating block.
// Assumes one clock, ref_clk, and a synchronous active-high reset.
`default_nettype none
module link_ctrl_asserts
  import link_ctrl_pkg::*;
#(parameter int CLEAR_LEN = CLEAR_CYCLES) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_out_valid,
  input wire logic [7:0] rx_out_data,
  input wire logic modem_hangup,
  input wire logic clear_busy,
  input wire logic link_start,
  input wire logic link_to_remote_mem,
  input wire logic link_from_local_mem,
  input wire logic link_channel,
  input wire logic [1:0] link_finished,
  input wire logic link_done,
  input wire logic link_abnormal
);
  logic done_seen;
  logic cfg_ok;
  logic [1:0] ch_busy;
  logic [9:0] cfg;
  wire clr_wr = reg_wr && reg_addr == CLEAR_REQ_ADDR;
  wire cfg_wr = reg_wr && reg_addr == LINK_CFG_ADDR;
  wire cmd = reg_wr && reg_addr == LINK_CMD_ADDR;
  wire [4:0] sel = reg_wdata[0] ? cfg[9:5] : cfg[4:0];
  wire bad_fmt = sel[4:2] < FORMAT_MIN || sel[4:2] > FORMAT_MAX || sel[1];
  wire [1:0] start_ch = link_start ? (link_channel ? 2'b10 : 2'b01) : 2'b00;
  // Channel busy lags the design by a cycle, so it can only miss a refusal
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_seen <= 1'b0;
      cfg_ok <= 1'b0;
      ch_busy <= 2'b00;
    end else begin
      done_seen <= $fell(clear_busy) || (done_seen && !clr_wr);
      cfg_ok <= cfg_ok || cfg_wr;
      ch_busy <= (ch_busy & ~link_finished) | start_ch;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (cfg_wr) begin
      cfg <= {reg_wdata[12:8], reg_wdata[4:0]};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_key;
    clr_wr && reg_wdata == CLEAR_KEY && !clear_busy;
  endsequence
  sequence s_refuse;
    link_done && link_abnormal && !link_start;
  endsequence
  property p_key; s_key |=> clear_busy && modem_hangup; endproperty
  a_key: assert property (p_key) else $error("clear start without hangup");
  property p_ends; $rose(clear_busy) |-> ##[1:200] !clear_busy; endproperty
  a_ends: assert property (p_ends) else $error("clear never ends");
  property p_zero;
    reg_rd && reg_addr == CLEAR_REQ_ADDR && done_seen && !clear_busy |=> reg_rdata == CLEAR_DONE;
  endproperty
  a_zero: assert property (p_zero) else $error("request word not zeroed");
  property p_nokey;
    clr_wr && reg_wdata != CLEAR_KEY && !clear_busy |=> !clear_busy;
  endproperty
  a_nokey: assert property (p_nokey) else $error("clear without key");
  property p_drop; rx_valid && clear_busy |=> !rx_out_valid; endproperty
  a_drop: assert property (p_drop) else $error("byte passed during clear");
  property p_pass;
    rx_valid && !clear_busy && !reg_wr |=> rx_out_valid && rx_out_data == $past(rx_data);
  endproperty
  a_pass: assert property (p_pass) else $error("byte lost outside clear");
  property p_busy; cmd && ch_busy[reg_wdata[0]] |=> s_refuse; endproperty
  a_busy: assert property (p_busy) else $error("busy channel accepted");
  property p_fmt; cmd && cfg_ok && bad_fmt |=> s_refuse; endproperty
  a_fmt: assert property (p_fmt) else $error("bad channel mode accepted");
  property p_dir; link_start |-> link_from_local_mem == !link_to_remote_mem; endproperty
  a_dir: assert property (p_dir) else $error("link direction wrong");
endmodule : link_ctrl_asserts
bind link_ctrl link_ctrl_asserts #(.CLEAR_LEN(CLEAR_LEN)) chk (.ref_clk, .reset, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_data, .rx_out_valid, .rx_out_data,
  .modem_hangup, .clear_busy, .link_start, .link_to_remote_mem, .link_from_local_mem,
  .link_channel, .link_finished, .link_done, .link_abnormal);
`default_nettype wire

// File: far_station.sv
// Far side model: serial receiver and remote station finishing link transfers.
// Assumes the bench commands latency, failure and received bytes.
`default_nettype none
module far_station (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic link_start,
  input wire logic link_channel,
  input wire logic [3:0] lat,
  input wire logic fail,
  input wire logic rx_go,
  input wire logic [7:0] rx_byte,
  output logic [1:0] link_finished,
  output logic link_failed,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [3:0] wait_cnt;
  logic ch;
  logic run;
  wire fin = run && wait_cnt == 4'h0;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      link_finished <= 2'b00;
      link_failed <= 1'b0;
    end else begin
      rx_valid <= rx_go;
      // Idle data toggles so a stale byte never looks fresh
      rx_data <= rx_go ? rx_byte : ~rx_data;
      link_finished <= fin ? (ch ? 2'b10 : 2'b01) : 2'b00;
      link_failed <= fin ? fail : ~link_failed;
      if (link_start) begin
        run <= 1'b1;
        ch <= link_channel;
        wait_cnt <= lat;
      end else if (run) begin
        wait_cnt <= wait_cnt - 4'h1;
        run <= !fin;
      end
    end
  end
endmodule : far_station
`default_nettype wire

// File: link_ctrl_bench.sv
// Self-checking bench for the clear handshake and link gating block.
// Drives the register port and the far side model on one 250 MHz clock.
`default_nettype none
module link_ctrl_bench
  import link_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, reg_wr, reg_rd, rx_go, fail, rx_valid, rx_out_valid, modem_hangup;
  logic clear_busy, link_start, to_rem, from_loc, link_channel, link_failed, link_done, link_abn;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0] rx_data, rx_out_data;
  logic [1:0] link_finished;
  logic [3:0] lat;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  link_ctrl #(.CLEAR_LEN(4)) DUT (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ch1_seq_in(16'h0005), .ch2_seq_in(16'h0007), .rx_valid, .rx_data,
    .rx_out_valid, .rx_out_data, .modem_hangup, .clear_busy, .link_start,
    .link_to_remote_mem(to_rem), .link_from_local_mem(from_loc), .link_channel,
    .link_finished, .link_failed, .link_done, .link_abnormal(link_abn));
  far_station far (.ref_clk, .reset, .link_start, .link_channel, .lat, .fail, .rx_go,
    .rx_byte(8'hA5), .link_finished, .link_failed, .rx_valid, .rx_data);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd
  task rx_watch(input int exp);
    int n;
    n = 0;
    @(posedge ref_clk);
    rx_go <= 1'b1;
    @(posedge ref_clk);
    rx_go <= 1'b0;
    repeat (4) begin
      @(posedge ref_clk);
      #1;
      if (rx_out_valid === 1'b1) n++;
    end
    chk(16'(n), 16'(exp));
  endtask : rx_watch
  task wait_done(input logic abn);
    // Let a refusal pulse from the previous command pass first
    @(posedge ref_clk);
    #1;
    for (int i = 0; i < 50 && link_done !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(16'({link_done, link_abn}), 16'({1'b1, abn}));
  endtask : wait_done
  task t_clear;
    rd(CLEAR_REQ_ADDR, CLEAR_REQ_RESET);
    wr(CLEAR_REQ_ADDR, 16'h1234);
    chk(16'(clear_busy), 16'h0000);
    rd(CLEAR_REQ_ADDR, 16'h1234);
    wr(CLEAR_REQ_ADDR, CLEAR_KEY);
    chk(16'({clear_busy, modem_hangup}), 16'h0003);
    rx_watch(0);
    for (int i = 0; i < 50 && clear_busy !== 1'b0; i++) @(posedge ref_clk);
    rd(CLEAR_REQ_ADDR, CLEAR_DONE);
    rd(CH1_SEQ_ADDR, SEQ_RESET_VALUE);
    rd(CH2_SEQ_ADDR, SEQ_RESET_VALUE);
    rx_watch(1);
  endtask : t_clear
  task t_link;
    wr(LINK_CFG_ADDR, 16'h1804);
    wr(LINK_CMD_ADDR, 16'h0000);
    chk(16'({link_start, to_rem, from_loc, link_channel}), 16'h000C);
    wr(LINK_CMD_ADDR, 16'h0000);
    chk(16'({link_done, link_abn}), 16'h0003);
    wait_done(1'b0);
    wr(LINK_CMD_ADDR, 16'h0001);
    chk(16'({link_done, link_abn}), 16'h0003);
    lat <= 4'h0;
    fail <= 1'b1;
    wr(LINK_CMD_ADDR, 16'hFE02);
    chk(16'({link_start, to_rem, from_loc, link_channel}), 16'h000A);
    wait_done(1'b1);
    wr(LINK_CFG_ADDR, 16'h0006);
    wr(LINK_CMD_ADDR, 16'h0000);
    chk(16'({link_done, link_abn}), 16'h0003);
    rd(LINK_STAT_ADDR, 16'h0010);
    rd(LINK_STAT_ADDR, 16'h0000);
  endtask : t_link
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    {reset, reg_wr, reg_rd, rx_go, fail, reg_addr, reg_wdata, lat} = {5'b10000, 28'h0, 4'h3};
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_clear();
    t_link();
    end_of_test();
  end
endmodule : link_ctrl_bench
`default_nettype wire
